// File: rtl/ssclk_pkg.sv
package ssclk_pkg;
  // Word offsets on the bus (byte addresses, aligned)
  localparam logic [3:0] ADDR_CONTROL  = 4'h0;
  localparam logic [3:0] ADDR_PIN_POS  = 4'h4;
  localparam logic [3:0] ADDR_DATA     = 4'h8;
  localparam logic [3:0] ADDR_STATUS   = 4'hc;
  localparam logic [3:0] ADDR_PORT     = 4'h0 + 4'h0; // unused alias guard
  // Control field positions
  localparam int CTL_TOGGLE_BIT   = 0;
  localparam int CTL_STROBE_BIT   = 1;
  localparam int CTL_SRC_LO_BIT   = 2;
  localparam int CTL_SRC_HI_BIT   = 3;
  localparam int CTL_WIRE_LO_BIT  = 4;
  localparam int CTL_WIRE_HI_BIT  = 5;
  // Pin position field
  localparam int POS_SELECT_BIT   = 0;
  // Status register: bit 7 clock port value, bit 6 clock direction, 3:0 counter
  localparam int STS_PORT_BIT     = 7;
  localparam int STS_DIR_BIT      = 6;
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] PIN_POS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic [3:0] COUNT_RESET   = 4'h0;
  // Clock source codes
  localparam logic [1:0] SRC_SOFT  = 2'h0;
  localparam logic [1:0] SRC_TIMER = 2'h1;
  // Pin positions
  localparam logic PORT_B = 1'b0;
  localparam logic PORT_A = 1'b1;
endpackage : ssclk_pkg

// File: rtl/ssclk_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ssclk_sync
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Asynchronous level in, synchronised level out
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : ssclk_sync
`default_nettype wire

// File: rtl/ssclk_top.sv
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ssclk_top
(
  // System
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Classic Wishbone slave
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [3:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  // Timer compare match pulse, same clock
  input  wire logic       timer_match,
  // Port B pins PB0 data in, PB1 data out, PB2 clock
  input  wire logic       pb0_in,
  output logic            pb1_out,
  output logic            pb1_oe_n,
  input  wire logic       pb2_in,
  output logic            pb2_out,
  output logic            pb2_oe_n,
  // Port A pins PA4 data in, PA2 data out, PA5 clock
  input  wire logic       pa4_in,
  output logic            pa2_out,
  output logic            pa2_oe_n,
  input  wire logic       pa5_in,
  output logic            pa5_out,
  output logic            pa5_oe_n,
  // Clock pin direction from port logic, 1 = output
  input  wire logic       clock_pin_direction_bit
);
  logic [1:0] clock_source_select_q;
  logic       clock_strobe_bit_q;
  logic [1:0] wire_mode_select_q;
  logic       pin_position_select_q;
  logic [7:0] shift_q;
  logic [3:0] count_q;
  logic       port_clk_q;
  logic       out_latch_q;
  logic       din_prev_q;
  logic       sclk_prev_q;
  logic       ack_q;
  logic [31:0] rdata_q;

  logic req;
  logic wr_ctl;
  logic wr_pos;
  logic wr_data;
  logic strobe_wr;
  logic toggle_wr;
  logic din_raw;
  logic clk_raw;
  logic din_s;
  logic sclk_s;
  logic ext_sel;
  logic sclk_rise;
  logic sclk_fall;
  logic sample_edge;
  logic shift_en;
  logic count_en;
  logic dout;
  logic clk_pin;

  assign req    = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_ctl = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == ssclk_pkg::ADDR_CONTROL);
  assign wr_pos = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == ssclk_pkg::ADDR_PIN_POS);
  assign wr_data = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == ssclk_pkg::ADDR_DATA);
  assign strobe_wr = wr_ctl && wb_dat_i[ssclk_pkg::CTL_STROBE_BIT];
  assign toggle_wr = wr_ctl && wb_dat_i[ssclk_pkg::CTL_TOGGLE_BIT];

  // Route pins by position select
  assign din_raw = pin_position_select_q ? pa4_in : pb0_in;
  assign clk_raw = pin_position_select_q ? pa5_in : pb2_in;

  ssclk_sync u_din_sync
  (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (din_raw),
    .sync_out (din_s)
  );

  ssclk_sync u_clk_sync
  (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (clk_raw),
    .sync_out (sclk_s)
  );

  // Edge finding on the synchronised clock only
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sclk_prev_q <= 1'b0;
    else
      sclk_prev_q <= sclk_s;
  end

  assign sclk_rise = sclk_s && !sclk_prev_q;
  assign sclk_fall = !sclk_s && sclk_prev_q;
  assign ext_sel   = clock_source_select_q[1];
  // Bit 0 of source picks positive (0) or negative (1) edge
  assign sample_edge = clock_source_select_q[0] ? sclk_fall : sclk_rise;

  // Shift clock source selection
  always_comb
  begin
    shift_en = 1'b0;
    count_en = 1'b0;
    if (ext_sel)
    begin
      shift_en = sample_edge;
      if (clock_strobe_bit_q)
        count_en = toggle_wr;
      else
        count_en = sclk_rise || sclk_fall;
    end
    else if (clock_source_select_q == ssclk_pkg::SRC_TIMER)
    begin
      shift_en = timer_match;
      count_en = timer_match;
    end
    else
    begin
      shift_en = strobe_wr;
      count_en = strobe_wr;
    end
  end

  // Control register; strobe and toggle are write actions
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clock_source_select_q <= ssclk_pkg::CONTROL_RESET[3:2];
      clock_strobe_bit_q    <= 1'b0;
      wire_mode_select_q    <= ssclk_pkg::CONTROL_RESET[5:4];
    end
    else if (wr_ctl)
    begin
      clock_source_select_q <= wb_dat_i[ssclk_pkg::CTL_SRC_HI_BIT:ssclk_pkg::CTL_SRC_LO_BIT];
      wire_mode_select_q    <= wb_dat_i[ssclk_pkg::CTL_WIRE_HI_BIT:ssclk_pkg::CTL_WIRE_LO_BIT];
      // Only held as a select when external clocking is chosen
      clock_strobe_bit_q    <= wb_dat_i[ssclk_pkg::CTL_STROBE_BIT]
                               && wb_dat_i[ssclk_pkg::CTL_SRC_HI_BIT];
    end
  end

  // Pin position register, only bit 0 storable
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pin_position_select_q <= ssclk_pkg::PIN_POS_RESET[0];
    else if (wr_pos)
      pin_position_select_q <= wb_dat_i[ssclk_pkg::POS_SELECT_BIT];
  end

  // Clock port value toggles regardless of direction
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      port_clk_q <= 1'b0;
    else if (toggle_wr)
      port_clk_q <= !port_clk_q;
  end

  // Previous-cycle input sample feeds software and timer shifts
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      din_prev_q <= 1'b0;
    else
      din_prev_q <= din_s;
  end

  // Data shift register; a bus write loads it, a shift wins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      shift_q <= ssclk_pkg::DATA_RESET;
    else if (shift_en)
      shift_q <= {shift_q[6:0], ext_sel ? din_s : din_prev_q};
    else if (wr_data)
      shift_q <= wb_dat_i[7:0];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      count_q <= ssclk_pkg::COUNT_RESET;
    else if (count_en)
      count_q <= count_q + 4'h1;
  end

  // Output latch updates on the edge opposite the sampling edge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      out_latch_q <= 1'b0;
    else if (ext_sel && (clock_source_select_q[0] ? sclk_rise : sclk_fall))
      out_latch_q <= shift_q[7];
  end

  // Transparent when not externally clocked
  assign dout = ext_sel ? out_latch_q : shift_q[7];

  // Three-wire drives data out; clock follows its port value
  assign clk_pin = port_clk_q;
  assign pb1_out  = dout;
  assign pa2_out  = dout;
  assign pb1_oe_n = !(wire_mode_select_q == 2'h1 && pin_position_select_q == ssclk_pkg::PORT_B);
  assign pa2_oe_n = !(wire_mode_select_q == 2'h1 && pin_position_select_q == ssclk_pkg::PORT_A);
  assign pb2_out  = clk_pin;
  assign pa5_out  = clk_pin;
  assign pb2_oe_n = !(clock_pin_direction_bit && pin_position_select_q == ssclk_pkg::PORT_B);
  assign pa5_oe_n = !(clock_pin_direction_bit && pin_position_select_q == ssclk_pkg::PORT_A);

  // Bus answer one cycle after request
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q   <= req;
      rdata_q <= 32'h0000_0000;
      if (req && !wb_we_i)
      begin
        case (wb_adr_i)
          ssclk_pkg::ADDR_CONTROL:
            rdata_q[7:0] <= {2'h0, wire_mode_select_q, clock_source_select_q,
                             2'h0};
          ssclk_pkg::ADDR_PIN_POS:
            rdata_q[7:0] <= {7'h00, pin_position_select_q};
          ssclk_pkg::ADDR_DATA:
            rdata_q[7:0] <= shift_q;
          ssclk_pkg::ADDR_STATUS:
            rdata_q[7:0] <= {port_clk_q, clock_pin_direction_bit, clock_strobe_bit_q,
                             1'b0, count_q};
          default:
            rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
endmodule : ssclk_top
`default_nettype wire

// File: testbench/ssclk_peer.sv
`timescale 1ns/10ps
`default_nettype none
module ssclk_peer
(
  // Frame request
  input wire logic       go,
  input wire logic [7:0] tx,
  // Link pins
  output logic           sck,
  output logic           sdo,
  output logic           busy
);
  initial
  begin
    {sck, sdo, busy} = 3'h0;
  end
  // Three bits msb first; data moves mid-low so either edge sees it settled
  always @(posedge go)
  begin
    busy = 1'b1;
    // Keep every pin change clear of the system clock edges
    #12;
    for (int i = 7; i > 4; i--)
    begin
      #100 sdo = tx[i];
      #100 sck = 1'b1;
      #200 sck = 1'b0;
    end
    #100 sdo = ~sdo;
    busy = 1'b0;
  end
endmodule : ssclk_peer
`default_nettype wire

// File: testbench/ssclk_props.sv
`timescale 1ns/10ps
`default_nettype none
module ssclk_props
(
  // System and bus
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Pins
  input wire logic        pb2_out,
  input wire logic        pb1_oe_n,
  input wire logic        pa2_oe_n,
  input wire logic        pb2_oe_n,
  input wire logic        pa5_oe_n,
  input wire logic        clock_pin_direction_bit
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire tog = req && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0] && wb_dat_i[0];
  a_ack_answer: assert property (req |=> wb_ack_o) else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
  a_toggle_flip: assert property (tog |=> pb2_out != $past(pb2_out)) else $error("no flip");
  a_toggle_hold: assert property (!tog |=> $stable(pb2_out)) else $error("stray flip");
  a_one_clock: assert property (pb2_oe_n || pa5_oe_n) else $error("two clock pins");
  a_one_dout: assert property (pb1_oe_n || pa2_oe_n) else $error("two data pins");
  a_dir_gate: assert property (!clock_pin_direction_bit |-> pb2_oe_n && pa5_oe_n)
    else $error("clock pin driven");
  a_ctl_zero: assert property (req && !wb_we_i && wb_adr_i == 4'h0 |=> wb_dat_o[1:0] == 2'h0)
    else $error("strobe bits read");
  a_pos_rsvd: assert property (req && !wb_we_i && wb_adr_i == 4'h4 |=> wb_dat_o[7:1] == 7'h0)
    else $error("reserved bits read");
endmodule : ssclk_props
bind ssclk_top ssclk_props i_props
(
  .clock                   (clock),
  .rst_n                   (rst_n),
  .wb_cyc_i                (wb_cyc_i),
  .wb_stb_i                (wb_stb_i),
  .wb_we_i                 (wb_we_i),
  .wb_adr_i                (wb_adr_i),
  .wb_sel_i                (wb_sel_i),
  .wb_dat_i                (wb_dat_i),
  .wb_dat_o                (wb_dat_o),
  .wb_ack_o                (wb_ack_o),
  .pb2_out                 (pb2_out),
  .pb1_oe_n                (pb1_oe_n),
  .pa2_oe_n                (pa2_oe_n),
  .pb2_oe_n                (pb2_oe_n),
  .pa5_oe_n                (pa5_oe_n),
  .clock_pin_direction_bit (clock_pin_direction_bit)
);
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock, rst_n, cyc, stb, we, tm, din, dir, go, pb1_out, pb1_oe_n, pb2_out, pb2_oe_n;
  logic pa5_oe_n, sck, sdo, busy, wb_ack_o, pa2_out, pa2_oe_n, pa5_out;
  logic [3:0] adr, sel, cnt;
  logic [7:0] tx;
  logic [31:0] wdat, q, wb_dat_o;
  logic [7:0] tcode [3] = '{8'h14, 8'h16, 8'h10};
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  ssclk_top i_dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .timer_match(tm), .pb0_in(busy ? sdo : din), .pb1_out(pb1_out), .pb1_oe_n(pb1_oe_n),
    .pb2_in(sck), .pb2_out(pb2_out), .pb2_oe_n(pb2_oe_n), .pa4_in(!din), .pa2_out(pa2_out),
    .pa2_oe_n(pa2_oe_n), .pa5_in(sck), .pa5_out(pa5_out), .pa5_oe_n(pa5_oe_n),
    .clock_pin_direction_bit(dir));
  ssclk_peer i_peer (.go(go), .tx(tx), .sck(sck), .sdo(sdo), .busy(busy));
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task finish_test;
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      finish_test;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Entered just after an edge; request stands until the edge that samples ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, 24'h0, d};
    @(posedge clock);
    while (wb_ack_o !== 1'b1) @(posedge clock);
    q = wb_dat_o;
    {cyc, stb} <= 2'h0;
    @(posedge clock);
  endtask : wb
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h0);
    chk(q, e);
  endtask : rc
  task automatic st(input logic p);
    wb(1'b0, 4'hc, 8'h0);
    chk(32'({q[7], q[3:0]}), 32'({p, cnt}));
  endtask : st
  task automatic t_ext(input logic [7:0] c, input logic [7:0] t, input logic [31:0] e,
    input logic [3:0] n);
    wr(4'h0, c);
    tx <= t;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    while (busy) @(posedge clock);
    // Two-stage synchroniser delay on the sensed pins
    repeat (4) @(posedge clock);
    cnt = cnt + n;
    rc(4'h8, e);
  endtask : t_ext
  initial
  begin
    {rst_n, cyc, stb, we, tm, din, go, adr, wdat, tx, cnt} = '0;
    sel = 4'hf;
    dir = 1'b1;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rc(4'h4, 32'h0);
    sel <= 4'h0;
    wr(4'h4, 8'hff);
    sel <= 4'hf;
    rc(4'h4, 32'h0);
    wr(4'h4, 8'hff);
    rc(4'h4, 32'h1);
    rc(4'h2, 32'h0);
    chk(32'({pb2_oe_n, pa5_oe_n}), 32'h2);
    wr(4'h4, 8'h0);
    chk(32'({pb2_oe_n, pa5_oe_n}), 32'h1);
    wr(4'h8, 8'h40);
    din <= 1'b1;
    repeat (4) @(posedge clock);
    wr(4'h0, 8'h12);
    cnt = 4'h1;
    rc(4'h8, 32'h81);
    chk(32'({pb1_out, pb1_oe_n}), 32'h2);
    rc(4'h0, 32'h10);
    st(1'b0);
    din <= 1'b0;
    foreach (tcode[i])
    begin
      wr(4'h0, tcode[i]);
      tm <= 1'b1;
      @(posedge clock);
      tm <= 1'b0;
      if (i < 2) cnt = cnt + 4'h1;
      st(1'b0);
    end
    rc(4'h8, 32'h4);
    t_ext(8'h18, 8'ha0, 32'h25, 4'h6);
    t_ext(8'h1c, 8'h60, 32'h2b, 4'h6);
    // Latch still holds the bit from the last rising edge, not shift bit 7
    chk(32'(pb1_out), 32'h1);
    st(1'b0);
    wr(4'h0, 8'h1a);
    wr(4'h0, 8'h1b);
    cnt = cnt + 4'h1;
    st(1'b1);
    rc(4'h0, 32'h18);
    t_ext(8'h1a, 8'h60, 32'h5b, 4'h0);
    st(1'b1);
    // Alternate position: data in comes from the inverted pin
    wr(4'h4, 8'h01);
    wr(4'h0, 8'h10);
    wr(4'h0, 8'h12);
    cnt = cnt + 4'h1;
    rc(4'h8, 32'hb7);
    chk(32'({pa2_out, pa2_oe_n, pa5_out, pa5_oe_n, pb1_oe_n, pb2_oe_n}), 32'h2b);
    dir <= 1'b0;
    wr(4'h0, 8'h11);
    st(1'b0);
    chk(32'({pa5_oe_n, pb2_oe_n}), 32'h3);
    finish_test;
  end
endmodule : testbench
`default_nettype wire
